/* File: agu_core.sv */
/*
 * agu_core: effective-address generation and pointer update for a 16-bit core.
 * assumes the decoder holds each request (pointer select) one cycle ahead on
 * pre_sel_i, then presents the request; result one cycle after the request.
 */
module agu_core #(
    parameter int unsigned PTR_NUM = agu_pkg::PTR_NUM,
    parameter int unsigned SEL_W   = agu_pkg::SEL_W
) (
    // clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                rstn_i,
    // decoder side
    input  wire logic [SEL_W-1:0]    pre_sel_i,
    input  wire agu_pkg::agu_req_s   req_i,
    input  wire agu_pkg::agu_wr_s    wr_i,
    // memory side
    output agu_pkg::agu_res_s        res_o,
    output logic [15:0]              ptr_new_o
);
    initial begin
        if (SEL_W != agu_pkg::SEL_W || PTR_NUM != (1 << SEL_W)) $error("agu_core: bad pointer count");
    end

    // reset release through two flops
    logic rst_meta_q;                 // first stage, read only by second
    logic rst_sync_q;                 // reset copy for the design
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // operands for the selected pointer set
    logic [15:0] ptr;                 // pointer value
    logic [15:0] ofs;                 // offset value
    logic [15:0] modf;                // modifier value
    logic        wb_en;               // pointer write-back strobe
    logic [15:0] wb_data;             // pointer write-back value

    agu_regfile #(
        .NUM (PTR_NUM),
        .SW  (SEL_W)
    ) u_regs (
        .clk_i     (core_clk_i),
        .rstn_i    (rst_sync_q),
        .rd_sel_i  (pre_sel_i),
        .ptr_o     (ptr),
        .ofs_o     (ofs),
        .modf_o    (modf),
        .wb_en_i   (wb_en),
        .wb_sel_i  (req_i.sel),
        .wb_data_i (wb_data),
        .wr_i      (wr_i)
    );

    // classify a modifier code
    function automatic agu_pkg::agu_arith_e arith_of(input logic [15:0] m);
        logic [14:0] lo;
        lo = m[14:0];
        if (m == agu_pkg::MOD_LINEAR)            arith_of = agu_pkg::AGU_AR_LINEAR;
        else if (m == agu_pkg::MOD_REVERSE)      arith_of = agu_pkg::AGU_AR_REVERSE;
        else if (m <= agu_pkg::MOD_MOD_MAX)      arith_of = agu_pkg::AGU_AR_MODULO;
        else if (lo != 15'h0000 && lo[14] == 1'b0 && ((lo + 15'h0001) & lo) == 15'h0000)
            arith_of = agu_pkg::AGU_AR_WRAP;
        else                                     arith_of = agu_pkg::AGU_AR_RESERVED;
    endfunction : arith_of

    // bit reversal of a word
    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int i = 0; i < 16; i++) rev16[i] = v[15-i];
    endfunction : rev16

    // pointer plus signed step under the given modifier
    function automatic logic [15:0] mod_add(input logic [15:0] p, input logic [15:0] step,
                                            input logic [15:0] m);
        logic [15:0] mask;            // modulo block mask 2^k-1
        logic [15:0] base;            // aligned buffer base
        logic [16:0] rel;             // offset inside buffer after step
        logic [15:0] size;            // modulus
        mask = 16'h0000;
        base = 16'h0000;
        rel  = 17'h00000;
        size = 16'h0000;
        unique case (arith_of(m))
            agu_pkg::AGU_AR_REVERSE: begin
                mod_add = rev16(rev16(p) + rev16(step));
            end
            agu_pkg::AGU_AR_MODULO: begin
                for (int i = 0; i < 16; i++) if (m[i]) mask = 16'hffff >> (15 - i);
                base = p & ~mask;
                size = m + 16'h0001;
                if (step[15] == 1'b0 && (step & mask) == 16'h0000 && step != 16'h0000) begin
                    mod_add = p + step;                                      // whole blocks forward
                end else if (step[15] && ((-step) & mask) == 16'h0000) begin
                    mod_add = p + step;                                      // whole blocks back
                end else begin
                    rel = {1'b0, p - base} + {step[15], step};
                    if (rel[16])                      rel = rel + {1'b0, size};
                    else if (rel[15:0] >= size)       rel = rel - {1'b0, size};
                    mod_add = base + rel[15:0];
                end
            end
            agu_pkg::AGU_AR_WRAP: begin
                mask    = {1'b0, m[14:0]};
                mod_add = (p & ~mask) | ((p + step) & mask);
            end
            default: begin
                mod_add = p + step;
            end
        endcase
    endfunction : mod_add

    // combinational address and write-back, same cycle as the request
    logic [15:0] ea;                  // effective address or operand
    logic        is_data;             // value is an operand
    logic        prog_ref;            // program memory reference
    always_comb begin
        ea       = ptr;
        is_data  = 1'b0;
        prog_ref = 1'b0;
        wb_en    = 1'b0;
        wb_data  = ptr;
        unique case (req_i.mode)
            agu_pkg::AGU_NO_UPDATE:    ea = ptr;
            agu_pkg::AGU_POST_INC1:    begin wb_en = 1'b1; wb_data = mod_add(ptr, 16'h0001, modf); end
            agu_pkg::AGU_POST_DEC1:    begin wb_en = 1'b1; wb_data = mod_add(ptr, 16'hffff, modf); end
            agu_pkg::AGU_POST_INC_OFS: begin wb_en = 1'b1; wb_data = mod_add(ptr, ofs, modf); end
            agu_pkg::AGU_POST_DEC_OFS: begin wb_en = 1'b1; wb_data = mod_add(ptr, -ofs, modf); end
            agu_pkg::AGU_INDEXED:      ea = mod_add(ptr, ofs, modf);
            agu_pkg::AGU_PRE_DEC1: begin
                ea      = mod_add(ptr, 16'hffff, modf);
                wb_en   = 1'b1;
                wb_data = ea;
            end
            agu_pkg::AGU_SHORT_DISP:
                ea = mod_add(ptr, 16'({{9{req_i.opcode[6]}}, req_i.opcode[6:0]}), modf);
            agu_pkg::AGU_LONG_DISP:    ea = mod_add(ptr, req_i.ext, modf);
            agu_pkg::AGU_PC_SHORT:     ea = req_i.pc + {{7{req_i.opcode[8]}}, req_i.opcode[8:0]};
            agu_pkg::AGU_PC_LONG:      ea = req_i.pc + req_i.ext;
            agu_pkg::AGU_PC_PTR:       ea = req_i.pc + ptr;
            agu_pkg::AGU_IMM_SHORT8:   begin ea = {8'h00, req_i.opcode[7:0]}; is_data = 1'b1; prog_ref = 1'b1; end
            agu_pkg::AGU_IMM_SHORT12:  begin ea = {4'h0, req_i.opcode[11:0]}; is_data = 1'b1; prog_ref = 1'b1; end
            agu_pkg::AGU_IMM_LONG:     begin ea = req_i.ext; is_data = 1'b1; prog_ref = 1'b1; end
            agu_pkg::AGU_ABS:          begin ea = req_i.ext; prog_ref = 1'b1; end
            agu_pkg::AGU_ABS_SHORT:    ea = {10'h000, req_i.opcode[5:0]};
            agu_pkg::AGU_JUMP_SHORT:   begin ea = {4'h0, req_i.opcode[11:0]}; prog_ref = 1'b1; end
            agu_pkg::AGU_IO_SHORT:     ea = {10'h3ff, req_i.opcode[5:0]};
            default:                   ea = ptr;
        endcase
        if (!req_i.valid) wb_en = 1'b0;
    end

    // reserved modifier only matters where the modifier is used
    logic uses_mod;
    assign uses_mod = req_i.mode inside {agu_pkg::AGU_POST_INC1, agu_pkg::AGU_POST_DEC1,
                                         agu_pkg::AGU_POST_INC_OFS, agu_pkg::AGU_POST_DEC_OFS,
                                         agu_pkg::AGU_INDEXED, agu_pkg::AGU_PRE_DEC1,
                                         agu_pkg::AGU_SHORT_DISP, agu_pkg::AGU_LONG_DISP};

    // registered result toward memory
    always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            res_o     <= '0;
            ptr_new_o <= agu_pkg::PTR_RST;
        end else begin
            res_o.valid    <= req_i.valid;
            res_o.addr     <= ea;
            res_o.is_data  <= is_data;
            res_o.prog_ref <= prog_ref;
            res_o.reserved <= req_i.valid && uses_mod && arith_of(modf) == agu_pkg::AGU_AR_RESERVED;
            ptr_new_o      <= wb_data;
        end
    end

    // checks; one clock domain, so the later ones lean on these defaults
    default clocking cb_core @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_sync_q);
    a_noupd_addr: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
        req_i.valid && req_i.mode == agu_pkg::AGU_NO_UPDATE |=> res_o.addr == $past(ptr) && !$past(wb_en))
        else $error("no-update address wrong");
    a_postinc_lin: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
        req_i.valid && req_i.mode == agu_pkg::AGU_POST_INC1 && modf == agu_pkg::MOD_LINEAR
        |=> res_o.addr == $past(ptr) && ptr_new_o == $past(ptr) + 16'h0001)
        else $error("post-increment wrong");
    a_postdec_lin: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
        req_i.valid && req_i.mode == agu_pkg::AGU_POST_DEC1 && modf == agu_pkg::MOD_LINEAR
        |=> ptr_new_o == $past(ptr) - 16'h0001)
        else $error("post-decrement wrong");
    a_index_keep: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
        req_i.valid && req_i.mode == agu_pkg::AGU_INDEXED |-> !wb_en)
        else $error("indexed mode updated pointer");
    a_predec_same: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
        req_i.valid && req_i.mode == agu_pkg::AGU_PRE_DEC1 |=> ptr_new_o == res_o.addr)
        else $error("pre-decrement mismatch");
    a_pc_short: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
        req_i.valid && req_i.mode == agu_pkg::AGU_PC_SHORT
        |=> res_o.addr == $past(req_i.pc) + {{7{$past(req_i.opcode[8])}}, $past(req_i.opcode[8:0])})
        else $error("short pc-relative wrong");
    a_io_short: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
        req_i.valid && req_i.mode == agu_pkg::AGU_IO_SHORT |=> res_o.addr[15:6] == 10'h3ff)
        else $error("i/o short not one-extended");
    a_rev_inc: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
        req_i.valid && req_i.mode == agu_pkg::AGU_POST_INC_OFS && modf == agu_pkg::MOD_REVERSE
        && ofs == 16'h8000 |=> ptr_new_o == rev16(rev16($past(ptr)) + 16'h0001))
        else $error("reverse carry wrong");
    a_mod_bound: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
        req_i.valid && req_i.mode == agu_pkg::AGU_POST_INC1 && modf == 16'h0004 && ptr[2:0] == 3'h4
        |=> ptr_new_o == {$past(ptr[15:3]), 3'h0})
        else $error("modulo wrap wrong");

    // a request of mode m taken at this edge
    sequence s_take(agu_pkg::agu_mode_e m);
        req_i.valid && req_i.mode == m;
    endsequence : s_take
    // the same request on a linear pointer set
    sequence s_lin(agu_pkg::agu_mode_e m);
        req_i.valid && req_i.mode == m && modf == agu_pkg::MOD_LINEAR;
    endsequence : s_lin

    // pointer used first, then offset added
    a_incofs_lin: assert property (s_lin(agu_pkg::AGU_POST_INC_OFS)
        |=> res_o.addr == $past(ptr) && ptr_new_o == $past(ptr) + $past(ofs))
        else $error("post-increment by offset wrong");
    // pointer used first, then offset taken off
    a_decofs_lin: assert property (s_lin(agu_pkg::AGU_POST_DEC_OFS)
        |=> res_o.addr == $past(ptr) && ptr_new_o == $past(ptr) - $past(ofs))
        else $error("post-decrement by offset wrong");
    // seven-bit field carries its sign into the upper bits
    a_sdisp_lin: assert property (s_lin(agu_pkg::AGU_SHORT_DISP)
        |=> res_o.addr == $past(ptr) + {{9{$past(req_i.opcode[6])}}, $past(req_i.opcode[6:0])}
        && ptr_new_o == $past(ptr))
        else $error("short displacement wrong");
    // extension word added, pointer left alone
    a_ldisp_lin: assert property (s_lin(agu_pkg::AGU_LONG_DISP)
        |=> res_o.addr == $past(ptr) + $past(req_i.ext) && ptr_new_o == $past(ptr))
        else $error("long displacement wrong");
    // opcode address plus extension, always linear
    a_pc_long: assert property (s_take(agu_pkg::AGU_PC_LONG)
        |=> res_o.addr == $past(req_i.pc) + $past(req_i.ext))
        else $error("long pc-relative wrong");
    // the set's modifier must not bend this sum
    a_pc_ptr: assert property (s_take(agu_pkg::AGU_PC_PTR)
        |=> res_o.addr == $past(req_i.pc) + $past(ptr) && ptr_new_o == $past(ptr))
        else $error("pointer pc-relative wrong");
    // eight-bit operand, upper byte clear
    a_imm_short: assert property (s_take(agu_pkg::AGU_IMM_SHORT8)
        |=> res_o.addr == {8'h00, $past(req_i.opcode[7:0])} && res_o.is_data)
        else $error("short immediate wrong");
    // full immediate rides on the program side
    a_imm_long: assert property (s_take(agu_pkg::AGU_IMM_LONG)
        |=> res_o.addr == $past(req_i.ext) && res_o.is_data && res_o.prog_ref)
        else $error("full immediate wrong");
    // extension word is the address itself
    a_abs_long: assert property (s_take(agu_pkg::AGU_ABS)
        |=> res_o.addr == $past(req_i.ext) && !res_o.is_data)
        else $error("absolute address wrong");
    // six-bit address, zeros above
    a_abs_short: assert property (s_take(agu_pkg::AGU_ABS_SHORT)
        |=> res_o.addr == {10'h000, $past(req_i.opcode[5:0])})
        else $error("absolute short wrong");
    // twelve-bit jump target, zeros above
    a_jump_short: assert property (s_take(agu_pkg::AGU_JUMP_SHORT)
        |=> res_o.addr == {4'h0, $past(req_i.opcode[11:0])} && res_o.prog_ref)
        else $error("short jump wrong");
    // wrap-around never leaves its block, whatever the offset
    a_wrap_block: assert property (s_take(agu_pkg::AGU_INDEXED)
        ##0 arith_of(modf) == agu_pkg::AGU_AR_WRAP
        |=> (res_o.addr & ~{1'b0, $past(modf[14:0])}) == ($past(ptr) & ~{1'b0, $past(modf[14:0])}))
        else $error("wrap-around left its block");
    // every request answered exactly one cycle later
    a_one_cycle: assert property (req_i.valid |=> res_o.valid)
        else $error("result not one cycle after request");

endmodule : agu_core

/* File: agu_dec_model.sv */
/*
 * agu_dec_model: decoder stand-in that loads registers and issues requests.
 * assumes the bench calls its tasks in turn; drives on the falling clock edge.
 */
module agu_dec_model (
    // clock
    input  wire logic         clk_i,
    // toward the address unit
    output logic [2:0]        pre_sel_o,
    output agu_pkg::agu_req_s req_o,
    output agu_pkg::agu_wr_s  wr_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle values before the first call
    initial begin
        pre_sel_o = 3'h0;
        req_o     = '0;
        wr_o      = '0;
    end

    // one-cycle register load pulse
    task automatic load(input logic [1:0] f, input logic [2:0] s, input logic [15:0] d);
        @(negedge clk_i);
        wr_o = '{valid: 1'b1, file: f, sel: s, data: d};
        @(negedge clk_i);
        wr_o.valid = 1'b0;
    endtask : load

    // select one cycle ahead, since the register read is registered
    task automatic issue(input agu_pkg::agu_mode_e m, input logic [2:0] s,
                         input logic [15:0] op, input logic [15:0] ext);
        @(negedge clk_i);
        pre_sel_o = s;
        @(negedge clk_i);
        // pc is the opcode word address
        req_o = '{valid: 1'b1, mode: m, sel: s, opcode: op, ext: ext, pc: 16'h3000};
        @(negedge clk_i);
        // fields no longer held: show a changed pattern, not the old value
        req_o = {1'b0, ~req_o[$bits(agu_pkg::agu_req_s)-2:0]};
    endtask : issue
endmodule : agu_dec_model

/* File: agu_pkg.sv */
/*
 * agu_pkg: shared constants and carriers for the address generation unit.
 * assumes a 16-bit core; the decoder drives one request word per cycle.
 */
package agu_pkg;

    localparam int unsigned DATA_W         = 16;          // address and pointer width
    localparam int unsigned PTR_NUM        = 8;           // pointer/offset/modifier sets
    localparam int unsigned SEL_W          = 3;           // pointer select width

    // modifier codes
    localparam logic [15:0] MOD_REVERSE    = 16'h0000;    // reverse-carry
    localparam logic [15:0] MOD_LINEAR     = 16'hffff;    // linear 16-bit
    localparam logic [15:0] MOD_MOD_MAX    = 16'h7fff;    // top plain modulo code
    localparam int unsigned MOD_WRAP_BIT   = 15;          // multiple wrap-around flag
    localparam int unsigned MOD_WRAP_MAXK  = 14;          // wrap-around modulus up to 2^14

    // instruction field positions / widths
    localparam int unsigned SDISP_W        = 7;           // short displacement
    localparam int unsigned PCDISP_W       = 9;           // short pc-relative displacement
    localparam int unsigned IMM8_W         = 8;           // short immediate (moves, and/or)
    localparam int unsigned IMM12_W        = 12;          // short immediate (loops)
    localparam int unsigned ABS_SHORT_W    = 6;           // absolute short address
    localparam int unsigned JMP_W          = 12;          // short jump address
    localparam int unsigned IO_SHORT_W     = 6;           // i/o short address

    // reset values
    localparam logic [15:0] PTR_RST        = 16'h0000;
    localparam logic [15:0] OFS_RST        = 16'h0000;
    localparam logic [15:0] MODF_RST       = 16'hffff;    // linear out of reset

    // addressing modes
    typedef enum logic [4:0] {
        AGU_NO_UPDATE,
        AGU_POST_INC1,
        AGU_POST_DEC1,
        AGU_POST_INC_OFS,
        AGU_POST_DEC_OFS,
        AGU_INDEXED,
        AGU_PRE_DEC1,
        AGU_SHORT_DISP,
        AGU_LONG_DISP,
        AGU_PC_SHORT,
        AGU_PC_LONG,
        AGU_PC_PTR,
        AGU_IMM_SHORT8,
        AGU_IMM_SHORT12,
        AGU_IMM_LONG,
        AGU_ABS,
        AGU_ABS_SHORT,
        AGU_JUMP_SHORT,
        AGU_IO_SHORT
    } agu_mode_e;

    // arithmetic kinds decoded from a modifier
    typedef enum logic [2:0] {
        AGU_AR_LINEAR,
        AGU_AR_REVERSE,
        AGU_AR_MODULO,
        AGU_AR_WRAP,
        AGU_AR_RESERVED
    } agu_arith_e;

    // request from the instruction decoder
    typedef struct packed {
        logic                  valid;      // one request per cycle
        agu_mode_e             mode;       // addressing mode
        logic [SEL_W-1:0]      sel;        // pointer set
        logic [15:0]           opcode;     // instruction word fields
        logic [15:0]           ext;        // extension word
        logic [15:0]           pc;         // opcode word address
    } agu_req_s;

    // register write from the core move path
    typedef struct packed {
        logic                  valid;
        logic [1:0]            file;       // 0 pointer, 1 offset, 2 modifier
        logic [SEL_W-1:0]      sel;
        logic [15:0]           data;
    } agu_wr_s;

    // result toward memory
    typedef struct packed {
        logic                  valid;
        logic [15:0]           addr;       // address or operand
        logic                  is_data;    // operand, not address
        logic                  prog_ref;   // program memory reference
        logic                  reserved;   // reserved modifier met
    } agu_res_s;

endpackage : agu_pkg

/* File: agu_regfile.sv */
/*
 * agu_regfile: pointer, offset and modifier banks with registered read-out.
 * assumes reads are requested one cycle ahead by the parent; async reset low.
 */
module agu_regfile #(
    parameter int unsigned NUM = 8,
    parameter int unsigned SW  = 3
) (
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            rstn_i,
    // read port
    input  wire logic [SW-1:0]   rd_sel_i,
    output logic      [15:0]     ptr_o,
    output logic      [15:0]     ofs_o,
    output logic      [15:0]     modf_o,
    // pointer write-back from the address unit
    input  wire logic            wb_en_i,
    input  wire logic [SW-1:0]   wb_sel_i,
    input  wire logic [15:0]     wb_data_i,
    // general register write
    input  wire agu_pkg::agu_wr_s wr_i
);
    initial begin
        if (NUM != (1 << SW)) $error("agu_regfile: NUM must equal 2**SW");
    end

    logic [15:0] ptr_q  [NUM];   // pointers
    logic [15:0] ofs_q  [NUM];   // offsets
    logic [15:0] modf_q [NUM];   // modifiers, one per pointer

    // bank update; write-back outranks a move to the same pointer
    genvar g;
    for (g = 0; g < NUM; g++) begin : g_bank
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                ptr_q[g]  <= agu_pkg::PTR_RST;
                ofs_q[g]  <= agu_pkg::OFS_RST;
                modf_q[g] <= agu_pkg::MODF_RST;
            end else begin
                if (wb_en_i && wb_sel_i == SW'(g)) begin
                    ptr_q[g] <= wb_data_i;
                end else if (wr_i.valid && wr_i.file == 2'h0 && wr_i.sel == SW'(g)) begin
                    ptr_q[g] <= wr_i.data;
                end
                if (wr_i.valid && wr_i.file == 2'h1 && wr_i.sel == SW'(g)) begin
                    ofs_q[g] <= wr_i.data;
                end
                if (wr_i.valid && wr_i.file == 2'h2 && wr_i.sel == SW'(g)) begin
                    modf_q[g] <= wr_i.data;
                end
            end
        end
    end

    // registered read-out, sampled before this edge's bank update
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ptr_o  <= agu_pkg::PTR_RST;
            ofs_o  <= agu_pkg::OFS_RST;
            modf_o <= agu_pkg::MODF_RST;
        end else begin
            ptr_o  <= ptr_q[rd_sel_i];
            ofs_o  <= ofs_q[rd_sel_i];
            modf_o <= modf_q[rd_sel_i];
        end
    end

endmodule : agu_regfile

/* File: test_agu_core.sv */
/*
 * test_agu_core: self-checking bench for the address generation core.
 * assumes the decoder model drives requests; a result shows within 3 cycles.
 */
module test_agu_core;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk;   // 100 MHz
    logic              rstn;       // active low
    logic [2:0]        pre_sel;
    agu_pkg::agu_req_s req;
    agu_pkg::agu_wr_s  wr;
    agu_pkg::agu_res_s res;
    logic [15:0]       ptr_new;
    int                num_errors;
    int                checked;

    agu_dec_model agu_dec_model_inst (.clk_i(core_clk), .pre_sel_o(pre_sel), .req_o(req), .wr_o(wr));
    agu_core agu_core_inst (.core_clk_i(core_clk), .rstn_i(rstn), .pre_sel_i(pre_sel), .req_i(req),
                            .wr_i(wr), .res_o(res), .ptr_new_o(ptr_new));

    // 16-bit value compare
    task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : cmp16

    // flag compare
    task automatic cmp1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : cmp1

    // pointer, offset, modifier of one set
    task automatic set(input logic [2:0] s, input logic [15:0] p, input logic [15:0] o, input logic [15:0] m);
        agu_dec_model_inst.load(2'h0, s, p);
        agu_dec_model_inst.load(2'h1, s, o);
        agu_dec_model_inst.load(2'h2, s, m);
    endtask : set

    // one request; issue leaves the idle cycle dependent requests need
    task automatic op(input agu_pkg::agu_mode_e m, input logic [2:0] s, input logic [15:0] oc,
                      input logic [15:0] ext, input logic [15:0] ea, input logic [15:0] wb);
        agu_dec_model_inst.issue(m, s, oc, ext);
        repeat (3) if (res.valid !== 1'b1) @(negedge core_clk);
        cmp1("valid", 1'b1, res.valid);
        cmp16("addr", ea, res.addr);
        cmp16("ptr_new", wb, ptr_new);
    endtask : op

    // linear steps across the 16-bit wrap
    task automatic t_linear;
        set(3'h0, 16'hfffe, 16'h0, 16'hffff);
        op(agu_pkg::AGU_NO_UPDATE, 3'h0, 16'h0, 16'h0, 16'hfffe, 16'hfffe);
        op(agu_pkg::AGU_POST_INC1, 3'h0, 16'h0, 16'h0, 16'hfffe, 16'hffff);
        op(agu_pkg::AGU_POST_INC1, 3'h0, 16'h0, 16'h0, 16'hffff, 16'h0000);
        op(agu_pkg::AGU_POST_DEC1, 3'h0, 16'h0, 16'h0, 16'h0000, 16'hffff);
        op(agu_pkg::AGU_NO_UPDATE, 3'h0, 16'h0, 16'h0, 16'hffff, 16'hffff);
    endtask : t_linear

    // offset modes and pre-decrement
    task automatic t_offset;
        set(3'h1, 16'h1000, 16'h0010, 16'hffff);
        op(agu_pkg::AGU_POST_INC_OFS, 3'h1, 16'h0, 16'h0, 16'h1000, 16'h1010);
        op(agu_pkg::AGU_POST_DEC_OFS, 3'h1, 16'h0, 16'h0, 16'h1010, 16'h1000);
        op(agu_pkg::AGU_INDEXED, 3'h1, 16'h0, 16'h0, 16'h1010, 16'h1000);
        op(agu_pkg::AGU_PRE_DEC1, 3'h1, 16'h0, 16'h0, 16'h0fff, 16'h0fff);
    endtask : t_offset

    // modulo 5, reverse carry, wrap-around 8, reserved code
    task automatic t_modifiers;
        set(3'h2, 16'h0104, 16'h0, 16'h0004);
        op(agu_pkg::AGU_POST_INC1, 3'h2, 16'h0, 16'h0, 16'h0104, 16'h0100);
        op(agu_pkg::AGU_POST_DEC1, 3'h2, 16'h0, 16'h0, 16'h0100, 16'h0104);
        set(3'h3, 16'h0, 16'h8000, 16'h0000);
        op(agu_pkg::AGU_POST_INC_OFS, 3'h3, 16'h0, 16'h0, 16'h0000, 16'h8000);
        op(agu_pkg::AGU_POST_INC_OFS, 3'h3, 16'h0, 16'h0, 16'h8000, 16'h4000);
        set(3'h4, 16'h0203, 16'h0014, 16'h8007);
        op(agu_pkg::AGU_INDEXED, 3'h4, 16'h0, 16'h0, 16'h0207, 16'h0203);
        op(agu_pkg::AGU_POST_INC_OFS, 3'h4, 16'h0, 16'h0, 16'h0203, 16'h0207);
        op(agu_pkg::AGU_POST_DEC_OFS, 3'h4, 16'h0, 16'h0, 16'h0207, 16'h0203);
        cmp1("reserved", 1'b0, res.reserved);
        set(3'h5, 16'h0010, 16'h0, 16'h8005);
        op(agu_pkg::AGU_POST_INC1, 3'h5, 16'h0, 16'h0, 16'h0010, 16'h0011);
        cmp1("reserved", 1'b1, res.reserved);
    endtask : t_modifiers

    // displacement and pc-relative forms
    task automatic t_disp;
        set(3'h6, 16'h2000, 16'h0, 16'hffff);
        op(agu_pkg::AGU_SHORT_DISP, 3'h6, 16'h0040, 16'h0, 16'h1fc0, 16'h2000);
        op(agu_pkg::AGU_LONG_DISP, 3'h6, 16'h0, 16'h0123, 16'h2123, 16'h2000);
        op(agu_pkg::AGU_PC_SHORT, 3'h6, 16'h0100, 16'h0, 16'h2f00, 16'h2000);
        op(agu_pkg::AGU_PC_LONG, 3'h6, 16'h0, 16'h0100, 16'h3100, 16'h2000);
        op(agu_pkg::AGU_PC_PTR, 3'h2, 16'h0, 16'h0, 16'h3104, 16'h0104);
    endtask : t_disp

    // special modes: upper bits of the fields must not leak
    task automatic t_special;
        op(agu_pkg::AGU_IMM_SHORT8, 3'h6, 16'hffab, 16'h0, 16'h00ab, 16'h2000);
        cmp1("is_data", 1'b1, res.is_data);
        op(agu_pkg::AGU_IMM_SHORT12, 3'h6, 16'hfabc, 16'h0, 16'h0abc, 16'h2000);
        op(agu_pkg::AGU_IMM_LONG, 3'h6, 16'h0, 16'hbeef, 16'hbeef, 16'h2000);
        cmp1("prog_ref", 1'b1, res.prog_ref);
        op(agu_pkg::AGU_ABS, 3'h6, 16'h0, 16'h4321, 16'h4321, 16'h2000);
        cmp1("is_data", 1'b0, res.is_data);
        cmp1("prog_ref", 1'b1, res.prog_ref);
        op(agu_pkg::AGU_ABS_SHORT, 3'h6, 16'hffea, 16'h0, 16'h002a, 16'h2000);
        cmp1("prog_ref", 1'b0, res.prog_ref);
        op(agu_pkg::AGU_JUMP_SHORT, 3'h6, 16'hf123, 16'h0, 16'h0123, 16'h2000);
        cmp1("prog_ref", 1'b1, res.prog_ref);
        op(agu_pkg::AGU_IO_SHORT, 3'h6, 16'h0015, 16'h0, 16'hffd5, 16'h2000);
    endtask : t_special

    // counts, verdict, end
    task automatic complete_run;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    // free-running clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // main sequence
    initial begin
        rstn       = 1'b0;
        num_errors = 0;
        checked    = 0;
        repeat (12) @(negedge core_clk);
        cmp1("valid in reset", 1'b0, res.valid);
        rstn = 1'b1;
        repeat (5) @(negedge core_clk);
        t_linear();
        t_offset();
        t_modifiers();
        t_disp();
        t_special();
        complete_run();
    end

    // watchdog: tests need well under 2000 cycles
    initial begin
        #100000;
        num_errors++;
        $display("unexpected run length: expected done seen hang");
        complete_run();
    end
endmodule : test_agu_core
